// [core/wdtb_consts.svh]
// offsets, field positions, reset values and timing figures of the watchdog
`ifndef WDTB_CONSTS_SVH
`define WDTB_CONSTS_SVH

// time base
`define WDTB_REF_CLK_HZ        100000000
`define WDTB_LF_OSC_HZ         31000
`define WDTB_BASE_INTERVAL_MS  1
`define WDTB_BASE_RATIO_LOG2   5
`define WDTB_MAX_SEL           5'h12
`define WDTB_CNT_W             24

// register byte offsets
`define WDTB_OFF_CTRL          8'h00
`define WDTB_OFF_STATUS        8'h04
`define WDTB_OFF_IRQ_STAT      8'h08
`define WDTB_OFF_IRQ_MASK      8'h0C
`define WDTB_OFF_COUNT         8'h10

// watchdog_control fields and reset
`define WDTB_CTRL_EN_BIT       0
`define WDTB_CTRL_SEL_LSB      1
`define WDTB_CTRL_SEL_MSB      5
`define WDTB_SEL_RESET         5'h0B
`define WDTB_EN_RESET          1'h0

// status register bits
`define WDTB_ST_PD_BIT         0
`define WDTB_ST_TO_BIT         1
`define WDTB_ST_ACTIVE_BIT     2
`define WDTB_ST_ASLEEP_BIT     3

// interrupt event bits
`define WDTB_IRQ_W             3
`define WDTB_IRQ_RESET_BIT     0
`define WDTB_IRQ_WAKE_BIT      1
`define WDTB_IRQ_OSCF_BIT      2

`endif

// [core/wdtb_pkg.sv]
// types shared by the watchdog files
package wdtb_pkg;

    typedef enum logic [1:0] {
        WDTB_MODE_OFF    = 2'h0,
        WDTB_MODE_SW     = 2'h1,
        WDTB_MODE_NOSLP  = 2'h2,
        WDTB_MODE_ALWAYS = 2'h3
    } wdtb_mode_t;

    typedef enum logic [1:0] {
        WDTB_PW_AWAKE  = 2'h0,
        WDTB_PW_ASLEEP = 2'h1,
        WDTB_PW_WAKING = 2'h3
    } wdtb_pw_state_t;

endpackage

// [core/wdtb_sync.sv]
// two-flop synchroniser with a third stage for rising-edge detection
`timescale 1ns/1ps
`default_nettype none

module wdtb_sync (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // asynchronous level in
    input  wire logic i_async,
    // synchronised rise, one cycle
    output logic      o_rise
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // meta_ff feeds sync_ff only
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_ff <= 1'h0;
            sync_ff <= 1'h0;
            last_ff <= 1'h0;
        end else if (i_ce) begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign o_rise = i_ce & sync_ff & ~last_ff;

endmodule

`default_nettype wire

// [core/wdtb_prescale.sv]
// watchdog counter: counts oscillator ticks up to the selected ratio
`timescale 1ns/1ps
`default_nettype none
`include "wdtb_consts.svh"

module wdtb_prescale (
    // clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_ce,
    // control
    input  wire logic                   i_tick,
    input  wire logic                   i_clear,
    input  wire logic                   i_active,
    input  wire logic [4:0]             i_sel,
    // state
    output logic [`WDTB_CNT_W-1:0]      o_count,
    output logic                        o_timeout
);

    logic [`WDTB_CNT_W-1:0] cnt_ff;
    logic                   to_ff;
    logic [`WDTB_CNT_W-1:0] limit;
    logic                   at_limit;

    // ratio is 32 doubled per code; reserved codes fall back to 1:32
    always_comb begin
        if (i_sel <= `WDTB_MAX_SEL)
            limit = (`WDTB_CNT_W'(1) << (i_sel + 5'(`WDTB_BASE_RATIO_LOG2)))
                    - `WDTB_CNT_W'(1);
        else
            limit = (`WDTB_CNT_W'(1) << `WDTB_BASE_RATIO_LOG2)
                    - `WDTB_CNT_W'(1);
    end

    // a period shortened mid-count must still expire, hence >=
    assign at_limit = (cnt_ff >= limit);

    // count advances only on oscillator ticks; a clear or an inactive watchdog zeroes it on any cycle with i_ce high
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_ff <= '0;
            to_ff  <= 1'h0;
        end else if (i_ce) begin
            to_ff <= 1'h0;
            if (i_clear || !i_active) begin
                cnt_ff <= '0;
            end else if (i_tick) begin
                if (at_limit) begin
                    cnt_ff <= '0;
                    to_ff  <= 1'h1;
                end else begin
                    cnt_ff <= cnt_ff + `WDTB_CNT_W'(1);
                end
            end
        end
    end

    assign o_count   = cnt_ff;
    assign o_timeout = to_ff;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_reserved_min;
        (i_sel > `WDTB_MAX_SEL) |-> (limit == `WDTB_CNT_W'h00_001F);
    endproperty
    a_reserved_min: assert property (p_reserved_min)
        else $error("reserved period code not at minimum ratio");

    property p_wrap;
        i_ce && i_tick && i_active && !i_clear && at_limit
            |=> o_timeout && (cnt_ff == '0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap with timeout at limit");

endmodule

`default_nettype wire

// [core/wdtb_top.sv]
// watchdog timer block: APB registers, sleep tracking, reset and wake control
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "wdtb_consts.svh"

module wdtb_top (
    // clock, reset, enable
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // oscillator and configuration
    input  wire logic        i_low_freq_internal_osc,
    input  wire logic [1:0]  i_wdt_mode_cfg,
    input  wire logic        i_osc_startup_timer,
    input  wire logic        i_osc_fail,
    // core events, one-cycle pulses
    input  wire logic        i_clear_watch_instruction,
    input  wire logic        i_sleep_enter,
    input  wire logic        i_wake,
    // results
    output logic             o_wdt_reset,
    output logic             o_wdt_wake,
    output logic             o_timeout_status_flag,
    output logic             o_powerdown_status_flag,
    output logic             o_irq
);

    wdtb_pkg::wdtb_pw_state_t pw_ff;
    wdtb_pkg::wdtb_pw_state_t nxt_pw;

    logic [4:0]             sel_ff;
    logic                   sw_watch_enable_ff;
    logic                   to_flag_ff;
    logic                   pd_flag_ff;
    logic [`WDTB_IRQ_W-1:0] irq_stat_ff;
    logic [`WDTB_IRQ_W-1:0] irq_mask_ff;
    logic [`WDTB_IRQ_W-1:0] irq_event;
    logic [`WDTB_IRQ_W-1:0] irq_w1c;
    logic                   irq_ff;
    logic                   rst_out_ff;
    logic                   wake_out_ff;
    logic [31:0]            prdata_ff;
    logic                   pready_ff;
    logic                   pslverr_ff;
    logic [31:0]            nxt_rdata;
    logic                   addr_hit;

    logic                   lf_tick;
    logic                   asleep;
    logic                   wdt_active;
    logic                   sleep_ok;
    logic                   wake_any;
    logic                   cnt_clear;
    logic [`WDTB_CNT_W-1:0] count;
    logic                   timeout;
    logic                   setup;
    logic                   wr_en;

    // oscillator pin is asynchronous to the reference clock
    wdtb_sync u_lf_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_async   (i_low_freq_internal_osc),
        .o_rise    (lf_tick)
    );

    assign asleep = (pw_ff == wdtb_pkg::WDTB_PW_ASLEEP);

    // mode decode
    always_comb begin
        case (wdtb_pkg::wdtb_mode_t'(i_wdt_mode_cfg))
            wdtb_pkg::WDTB_MODE_ALWAYS: wdt_active = 1'h1;
            wdtb_pkg::WDTB_MODE_NOSLP:  wdt_active = !asleep;
            wdtb_pkg::WDTB_MODE_SW:     wdt_active = sw_watch_enable_ff;
            wdtb_pkg::WDTB_MODE_OFF:    wdt_active = 1'h0;
            default:                    wdt_active = 1'h0;
        endcase
    end

    // sleep entry only counts from the awake state
    assign sleep_ok = i_sleep_enter && (pw_ff == wdtb_pkg::WDTB_PW_AWAKE);
    assign wake_any = asleep && (i_wake || timeout);

    // pulses act at once, far inside one oscillator period
    assign cnt_clear = i_clear_watch_instruction
                     || sleep_ok
                     || wake_any
                     || i_osc_fail
                     || i_osc_startup_timer;

    wdtb_prescale u_prescale (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_tick    (lf_tick),
        .i_clear   (cnt_clear),
        .i_active  (wdt_active),
        .i_sel     (sel_ff),
        .o_count   (count),
        .o_timeout (timeout)
    );

    // power state tracking
    always_comb begin
        nxt_pw = pw_ff;
        case (pw_ff)
            wdtb_pkg::WDTB_PW_AWAKE:
                if (i_sleep_enter)
                    nxt_pw = wdtb_pkg::WDTB_PW_ASLEEP;
            wdtb_pkg::WDTB_PW_ASLEEP:
                if (timeout)
                    nxt_pw = wdtb_pkg::WDTB_PW_WAKING;
                else if (i_wake)
                    nxt_pw = wdtb_pkg::WDTB_PW_AWAKE;
            wdtb_pkg::WDTB_PW_WAKING:
                nxt_pw = wdtb_pkg::WDTB_PW_AWAKE;
            default:
                nxt_pw = wdtb_pkg::WDTB_PW_AWAKE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst)
            pw_ff <= wdtb_pkg::WDTB_PW_AWAKE;
        else if (i_ce)
            pw_ff <= nxt_pw;
    end

    // reset and wake outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rst_out_ff  <= 1'h0;
            wake_out_ff <= 1'h0;
        end else if (i_ce) begin
            rst_out_ff  <= timeout && !asleep;
            wake_out_ff <= timeout && asleep;
        end
    end

    // timeout and powerdown flags; a timeout outranks other updates
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            to_flag_ff <= 1'h1;
            pd_flag_ff <= 1'h1;
        end else if (i_ce) begin
            if (timeout && asleep) begin
                to_flag_ff <= 1'h0;
                pd_flag_ff <= 1'h0;
            end else if (timeout) begin
                to_flag_ff <= 1'h0;
                pd_flag_ff <= 1'h1;
            end else if (sleep_ok) begin
                to_flag_ff <= 1'h1;
                pd_flag_ff <= 1'h0;
            end else if (i_clear_watch_instruction) begin
                to_flag_ff <= 1'h1;
                pd_flag_ff <= 1'h1;
            end
        end
    end

    // apb: pready raised one cycle after setup, zero wait states
    assign setup    = i_psel && !i_penable && !pready_ff;
    assign wr_en    = i_psel && i_penable && pready_ff && i_pwrite
                      && !pslverr_ff;
    assign addr_hit = (i_paddr == `WDTB_OFF_CTRL)
                   || (i_paddr == `WDTB_OFF_STATUS)
                   || (i_paddr == `WDTB_OFF_IRQ_STAT)
                   || (i_paddr == `WDTB_OFF_IRQ_MASK)
                   || (i_paddr == `WDTB_OFF_COUNT);

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (i_paddr)
            `WDTB_OFF_CTRL: begin
                nxt_rdata[`WDTB_CTRL_SEL_MSB:`WDTB_CTRL_SEL_LSB] = sel_ff;
                nxt_rdata[`WDTB_CTRL_EN_BIT] = sw_watch_enable_ff;
            end
            `WDTB_OFF_STATUS: begin
                nxt_rdata[`WDTB_ST_PD_BIT]     = pd_flag_ff;
                nxt_rdata[`WDTB_ST_TO_BIT]     = to_flag_ff;
                nxt_rdata[`WDTB_ST_ACTIVE_BIT] = wdt_active;
                nxt_rdata[`WDTB_ST_ASLEEP_BIT] = asleep;
            end
            `WDTB_OFF_IRQ_STAT:
                nxt_rdata[`WDTB_IRQ_W-1:0] = irq_stat_ff;
            `WDTB_OFF_IRQ_MASK:
                nxt_rdata[`WDTB_IRQ_W-1:0] = irq_mask_ff;
            `WDTB_OFF_COUNT:
                nxt_rdata[`WDTB_CNT_W-1:0] = count;
            default:
                nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pready_ff  <= 1'h0;
            pslverr_ff <= 1'h0;
            prdata_ff  <= 32'h0000_0000;
        end else if (i_ce) begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !addr_hit;
            if (setup && !i_pwrite)
                prdata_ff <= nxt_rdata;
            else if (!setup)
                prdata_ff <= 32'h0000_0000;
        end
    end

    // control register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sel_ff             <= `WDTB_SEL_RESET;
            sw_watch_enable_ff <= `WDTB_EN_RESET;
        end else if (i_ce && wr_en && i_pstrb[0]
                     && i_paddr == `WDTB_OFF_CTRL) begin
            sel_ff <= i_pwdata[`WDTB_CTRL_SEL_MSB:`WDTB_CTRL_SEL_LSB];
            sw_watch_enable_ff <= i_pwdata[`WDTB_CTRL_EN_BIT];
        end
    end

    // interrupt status: write one to clear, a new event wins over the clear
    assign irq_event[`WDTB_IRQ_RESET_BIT] = timeout && !asleep;
    assign irq_event[`WDTB_IRQ_WAKE_BIT]  = timeout && asleep;
    assign irq_event[`WDTB_IRQ_OSCF_BIT]  = i_osc_fail;
    assign irq_w1c = (wr_en && i_pstrb[0] && i_paddr == `WDTB_OFF_IRQ_STAT)
                     ? i_pwdata[`WDTB_IRQ_W-1:0] : '0;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            irq_ff      <= 1'h0;
        end else if (i_ce) begin
            irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | irq_event;
            if (wr_en && i_pstrb[0] && i_paddr == `WDTB_OFF_IRQ_MASK)
                irq_mask_ff <= i_pwdata[`WDTB_IRQ_W-1:0];
            irq_ff <= |(((irq_stat_ff & ~irq_w1c) | irq_event)
                        & irq_mask_ff);
        end
    end

    assign o_prdata                = prdata_ff;
    assign o_pready                = pready_ff;
    assign o_pslverr               = pslverr_ff;
    assign o_wdt_reset             = rst_out_ff;
    assign o_wdt_wake              = wake_out_ff;
    assign o_timeout_status_flag   = to_flag_ff;
    assign o_powerdown_status_flag = pd_flag_ff;
    assign o_irq                   = irq_ff;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_mode_always;
        i_ce && i_wdt_mode_cfg == 2'h3 && asleep && lf_tick && !cnt_clear
            && count == 24'h00_0000 |=> count == 24'h00_0001;
    endproperty
    a_mode_always: assert property (p_mode_always)
        else $error("always-on watchdog did not count in sleep");

    property p_mode_nosleep;
        i_ce && i_wdt_mode_cfg == 2'h2 && asleep |=> count == '0;
    endproperty
    a_mode_nosleep: assert property (p_mode_nosleep)
        else $error("watchdog counted in sleep with mode 10");

    property p_mode_sw_off;
        i_ce && i_wdt_mode_cfg == 2'h1 && !sw_watch_enable_ff
            |=> count == '0;
    endproperty
    a_mode_sw_off: assert property (p_mode_sw_off)
        else $error("watchdog counted with software enable low");

    property p_mode_off;
        i_ce && i_wdt_mode_cfg == 2'h0 |=> count == '0;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("watchdog counted in mode 00");

    property p_reset_values;
        $past(i_rst) |-> sel_ff == 5'h0B && !sw_watch_enable_ff;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("control register reset value wrong");

    property p_clear_event;
        i_ce && (i_clear_watch_instruction || i_osc_fail
                 || i_osc_startup_timer) |=> count == '0;
    endproperty
    a_clear_event: assert property (p_clear_event)
        else $error("count not cleared by clear event");

    property p_sleep_wake;
        i_ce && timeout && asleep
            |=> o_wdt_wake && !o_wdt_reset && !o_timeout_status_flag
                && !o_powerdown_status_flag;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep timeout did not wake cleanly");

    property p_ctrl_upper_zero;
        o_pready && i_paddr == `WDTB_OFF_CTRL |-> o_prdata[31:6] == '0;
    endproperty
    a_ctrl_upper_zero: assert property (p_ctrl_upper_zero)
        else $error("control register upper bits not zero");

    property p_awake_reset;
        i_ce && timeout && !asleep |=> o_wdt_reset ##1 !o_wdt_reset;
    endproperty
    a_awake_reset: assert property (p_awake_reset)
        else $error("awake timeout did not give a one-cycle reset");

    property p_sleep_flags;
        i_ce && sleep_ok && !timeout
            |=> !o_powerdown_status_flag && o_timeout_status_flag;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags)
        else $error("flags wrong after sleep entry");

    c_awake_reset: cover property (o_wdt_reset);
    c_sleep_wake:  cover property (o_wdt_wake);
    c_ctrl_write:  cover property (wr_en && i_paddr == `WDTB_OFF_CTRL);
    c_irq:         cover property (o_irq);

endmodule

`default_nettype wire

// [tb/wdtb_core_model.sv]
// core, oscillator and clock-monitor model facing the watchdog
`timescale 1ns/1ps
`default_nettype none

module wdtb_core_model (
    // clock
    input  wire logic i_ref_clk,
    // towards the watchdog
    output var logic  o_osc,
    output var logic  o_clear,
    output var logic  o_sleep,
    output var logic  o_wake,
    output var logic  o_ost,
    output var logic  o_oscf
);
    initial begin
        o_osc   = 1'b0;
        o_clear = 1'b0;
        o_sleep = 1'b0;
        o_wake  = 1'b0;
        o_ost   = 1'b0;
        o_oscf  = 1'b0;
    end

    // half period of 4 cycles keeps edges clear of the synchroniser
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (4) @(posedge i_ref_clk);
            o_osc <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            o_osc <= 1'b0;
        end
    endtask

    // 0 clear, 1 sleep, 2 wake, 3 oscillator fail; one cycle each
    task automatic pulse(input int which);
        @(posedge i_ref_clk);
        case (which)
            0: o_clear <= 1'b1;
            1: o_sleep <= 1'b1;
            2: o_wake  <= 1'b1;
            default: o_oscf <= 1'b1;
        endcase
        @(posedge i_ref_clk);
        o_clear <= 1'b0;
        o_sleep <= 1'b0;
        o_wake  <= 1'b0;
        o_oscf  <= 1'b0;
    endtask

    task automatic set_ost(input logic v);
        @(posedge i_ref_clk);
        o_ost <= v;
    endtask
endmodule

`default_nettype wire

// [tb/tb_wdtb_top.sv]
// self-checking bench of the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
`include "wdtb_consts.svh"

module tb_wdtb_top;
    typedef struct packed {
        logic [1:0]  kind;
        logic [32:0] val;
    } wdtb_note_t;

    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [1:0]  cfg;
    logic        ce;
    logic [3:0]  strb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc;
    logic        clr;
    logic        slp;
    logic        wk;
    logic        osc_startup_timer;
    logic        oscf;
    logic        wdt_rst;
    logic        wdt_wake;
    logic        to_flag;
    logic        pd_flag;
    logic        irq;
    int          err_count;
    int          n_checks;
    wdtb_note_t  exp_q[$];

    wdtb_core_model i_core (
        .i_ref_clk(clk), .o_osc(osc), .o_clear(clr), .o_sleep(slp),
        .o_wake(wk), .o_ost(osc_startup_timer), .o_oscf(oscf)
    );

    wdtb_top i_dut (
        .i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(strb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr),
        .i_low_freq_internal_osc(osc), .i_wdt_mode_cfg(cfg),
        .i_osc_startup_timer(osc_startup_timer), .i_osc_fail(oscf),
        .i_clear_watch_instruction(clr), .i_sleep_enter(slp),
        .i_wake(wk), .o_wdt_reset(wdt_rst), .o_wdt_wake(wdt_wake),
        .o_timeout_status_flag(to_flag),
        .o_powerdown_status_flag(pd_flag), .o_irq(irq)
    );

    always #5 clk = ~clk;

    task automatic chk(input string nm, input logic [32:0] e,
                       input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // any result with no note waiting is checked against kind 3, which no result has
    task automatic take(input logic [1:0] k, input logic [32:0] v);
        wdtb_note_t n;
        if (exp_q.size() == 0) begin
            chk("event kind", 33'd3, {31'h0, k});
        end else begin
            n = exp_q.pop_front();
            chk("event kind", {31'h0, n.kind}, {31'h0, k});
            chk("event value", n.val, v);
        end
    endtask

    always @(posedge clk) begin
        if (!rst) begin
            if (pready === 1'b1 && pwrite === 1'b0)
                take(2'd0, {pslverr, prdata});
            if (wdt_rst === 1'b1)
                take(2'd1, 33'h0);
            if (wdt_wake === 1'b1)
                take(2'd2, 33'h0);
        end
    end

    // master waits on pready only; the bench watchdog bounds the wait
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back('{2'd0, e});
        apb(1'b0, a, $urandom);
    endtask

    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    task automatic arm(input logic [1:0] m, input logic [31:0] c);
        @(posedge clk);
        rst <= 1'b1;
        cfg <= m;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b1, `WDTB_OFF_CTRL, c);
        i_core.pulse(0);
    endtask

    // nothing may fire before the n-th tick, result right after it
    task automatic expect_to(input logic [1:0] k, input int n);
        i_core.ticks(n - 1);
        settle();
        exp_q.push_back('{k, 33'h0});
        i_core.ticks(1);
        settle();
        chk("notes left", 33'h0, 33'(exp_q.size()));
    endtask

    task automatic quiet;
        i_core.ticks(40);
        settle();
        chk("notes left", 33'h0, 33'(exp_q.size()));
    endtask

    initial begin
        clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0000_0000; cfg = 2'h3;
        err_count = 0; n_checks = 0;
        ce = 1'b1;
        strb = 4'hf;
        void'($urandom(80));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(`WDTB_OFF_CTRL, 33'h0_0000_0016);
        apb(1'b1, `WDTB_OFF_CTRL, $urandom | 32'h0000_00ff);
        rd(`WDTB_OFF_CTRL, 33'h0_0000_003f);
        strb <= 4'he;
        apb(1'b1, `WDTB_OFF_CTRL, 32'h0000_0000);
        strb <= 4'hf;
        rd(`WDTB_OFF_CTRL, 33'h0_0000_003f);  // lane 0 off: write ignored
        rd(8'h20, 33'h1_0000_0000);
        arm(wdtb_pkg::WDTB_MODE_ALWAYS, 32'h0000_0000);
        i_core.ticks($urandom_range(30, 1));
        i_core.pulse(0);
        i_core.ticks(5);
        rd(`WDTB_OFF_COUNT, 33'h0_0000_0005);
        @(posedge clk);
        ce <= 1'b0;
        i_core.ticks(3);
        @(posedge clk);
        ce <= 1'b1;
        rd(`WDTB_OFF_COUNT, 33'h0_0000_0005);  // frozen while ce low
        expect_to(2'd1, 27);
        rd(`WDTB_OFF_IRQ_STAT, 33'h0_0000_0001);
        chk("irq masked", 33'h0, {32'h0, irq});
        apb(1'b1, `WDTB_OFF_IRQ_MASK, 32'h0000_0007);
        repeat (3) @(posedge clk);
        chk("irq on", 33'h1, {32'h0, irq});
        apb(1'b1, `WDTB_OFF_IRQ_STAT, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("irq cleared", 33'h0, {32'h0, irq});
        for (int s = 0; s < 3; s++) begin
            arm(wdtb_pkg::WDTB_MODE_ALWAYS, 32'(s * 2));
            expect_to(2'd1, 32 << s);
        end
        for (int s = 19; s < 32; s++) begin
            arm(wdtb_pkg::WDTB_MODE_ALWAYS, 32'(s * 2));
            expect_to(2'd1, 32);
        end
        arm(wdtb_pkg::WDTB_MODE_OFF, 32'h0000_0001);
        quiet();
        arm(wdtb_pkg::WDTB_MODE_SW, 32'h0000_0000);
        quiet();
        arm(wdtb_pkg::WDTB_MODE_SW, 32'h0000_0001);
        expect_to(2'd1, 32);
        arm(wdtb_pkg::WDTB_MODE_NOSLP, 32'h0000_0000);
        expect_to(2'd1, 32);
        arm(wdtb_pkg::WDTB_MODE_NOSLP, 32'h0000_0000);
        i_core.pulse(1);
        quiet();
        arm(wdtb_pkg::WDTB_MODE_ALWAYS, 32'h0000_0000);
        i_core.ticks(10);
        i_core.pulse(1);
        settle();
        chk("to pd sleep", 33'h2, {31'h0, to_flag, pd_flag});
        rd(`WDTB_OFF_STATUS, 33'h0_0000_000e);
        expect_to(2'd2, 32);
        chk("to pd wake", 33'h0, {31'h0, to_flag, pd_flag});
        arm(wdtb_pkg::WDTB_MODE_ALWAYS, 32'h0000_0000);
        i_core.pulse(1);
        i_core.ticks(20);
        i_core.pulse(2);
        expect_to(2'd1, 32);
        arm(wdtb_pkg::WDTB_MODE_ALWAYS, 32'h0000_0000);
        i_core.ticks(20);
        i_core.pulse(3);
        expect_to(2'd1, 32);
        arm(wdtb_pkg::WDTB_MODE_ALWAYS, 32'h0000_0000);
        i_core.set_ost(1'b1);
        quiet();
        i_core.set_ost(1'b0);
        expect_to(2'd1, 32);
        tally_and_finish();
    end

    // whole run needs about 10000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("watchdog of the bench expired");
        tally_and_finish();
    end
endmodule

`default_nettype wire
